// ### logic/dsa_pkg.sv
package dsa_pkg;

  // ****************************************************************
  // Clock rate and conversion timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;          // System clock rate
  localparam int T_CONV_CH_NS = 400;     // Longest time per channel
  localparam int T_ACQ_NS = 250;         // Least self-run acquisition
  localparam int CONV_CYC_I = (T_CONV_CH_NS * CLK_MHZ) / 1000;
  localparam int ACQ_CYC_I = (T_ACQ_NS * CLK_MHZ + 999) / 1000;

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC_I - 1);
  localparam logic [CNT_W-1:0] ACQ_DONE = CNT_W'(ACQ_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // ****************************************************************
  // Result and serial frame layout
  // ****************************************************************
  localparam int RES_W = 16;
  localparam int BYTE_W = 8;
  localparam int FRAME_W = 32;
  localparam int BIT_W = 5;
  localparam logic [BIT_W-1:0] BIT_LAST = 5'h1F;
  localparam logic [BIT_W-1:0] BIT_ZERO = 5'h00;
  localparam logic [BIT_W-1:0] BIT_ONE = 5'h01;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;

  // Pin group order inside the synchroniser
  localparam int PIN_N = 9;
  // Idle levels: start, chip select and read strobe rest high
  localparam logic [PIN_N-1:0] PIN_IDLE = 9'h103;

  // Both channel codes of one sampled pair, straight binary
  typedef struct packed {
    logic [RES_W-1:0] ch_a;
    logic [RES_W-1:0] ch_b;
  } dsa_pair_t;

  // Control pins after synchronisation
  typedef struct packed {
    logic start_n;
    logic pd;
    logic impulse;
    logic pair_sel;
    logic ser;
    logic swap;
    logic pick;
    logic cs_n;
    logic rd_n;
  } dsa_pins_t;

  typedef enum logic [1:0] {
    DSA_ACQ,
    DSA_CONV_A,
    DSA_CONV_B
  } dsa_state_t;

endpackage : dsa_pkg

// ### logic/dsa_sync.sv
`timescale 1ns/1ps

// ******************************************************************
// Two-stage level synchroniser, one generate entry per bit
// ******************************************************************
module dsa_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      // First stage feeds only the second one; reset loads the idle
      // level so that no false edge follows the release of reset
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta <= RST[i];
          dout[i] <= RST[i];
        end else begin
          meta <= din[i];
          dout[i] <= meta;
        end
      end
    end
  endgenerate

endmodule : dsa_sync

// ### logic/dsa_ser_tx.sv
`timescale 1ns/1ps

// ******************************************************************
// Serial shifter on the host's serial clock
// ******************************************************************
module dsa_ser_tx (
  input  wire logic                        serial_clk,
  input  wire logic                        sys_rst,
  input  wire logic [dsa_pkg::FRAME_W-1:0] word,
  input  wire logic                        word_tgl,
  output logic                             serial_out_line
);

  logic                        tg_meta;
  logic                        tg_sync;
  logic                        tg_seen;
  logic [dsa_pkg::FRAME_W-1:0] shreg;
  logic [dsa_pkg::BIT_W-1:0]   bit_cnt;

  // Toggle crossing; word moves with the toggle and is still long before the load
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tg_meta <= 1'b0;
      tg_sync <= 1'b0;
      tg_seen <= 1'b0;
    end else begin
      tg_meta <= word_tgl;
      tg_sync <= tg_meta;
      tg_seen <= tg_sync;
    end
  end

  // Load on a new word, then one bit per clock, first bit on top
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shreg <= '0;
      bit_cnt <= dsa_pkg::BIT_ZERO;
      serial_out_line <= 1'b0;
    end else if (tg_sync != tg_seen) begin
      shreg <= word;
      bit_cnt <= dsa_pkg::BIT_ZERO;
      serial_out_line <= word[dsa_pkg::FRAME_W-1];
    end else if (bit_cnt != dsa_pkg::BIT_LAST) begin
      shreg <= {shreg[dsa_pkg::FRAME_W-2:0], 1'b0};
      bit_cnt <= bit_cnt + dsa_pkg::BIT_ONE;
      serial_out_line <= shreg[dsa_pkg::FRAME_W-2];
    end
  end

  property p_ser_load;
    @(posedge serial_clk) disable iff (sys_rst)
    (tg_sync != tg_seen) |=> serial_out_line == $past(word[31]);
  endproperty
  a_ser_load: assert property (p_ser_load)
    else $error("Serial frame does not open with the top bit");

endmodule : dsa_ser_tx

// ### logic/dsa_adc_if.sv
`timescale 1ns/1ps

// Notes on behaviour
// - A started conversion completes unless reset; no restart or power-down abort.
// - Start works whatever chip select and read strobe are doing.
// - Impulse mode: start held low after busy falls restarts by itself.
// - Self-restart only in impulse mode; normal mode needs each start edge.
// - Outputs float unless chip select and read strobe are both low.
// - Reset aborts any conversion and floats the data bus.
// - interface_select low picks parallel, high picks serial on shared pins.
// - Select and read tied low drive the bus continuously with results.
// - Results readable after conversion, in other channel's or next conversion.
// - byte_order_swap low: low byte on low lines; high swaps the bytes.
// - Parallel: channel_pick high shows channel A, low shows channel B.
// - Parallel A readable once A ends; serial words update after B.
// - Serial: both results as 32 bits, top bit first, one per clock.
// - Serial: channel_pick high sends A first, low sends B first.
// - Impulse mode lowers power after conversion; interface stays active.
// - input_pair_select picks the pair, held steady through acquisition.
// - Channel A of the pair is always converted before channel B.
// - Results are straight unsigned binary codes.
module dsa_adc_if (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               serial_clk,
  input  wire logic               conversion_start_n,
  input  wire logic               power_down,
  input  wire logic               impulse_mode,
  input  wire logic               input_pair_select,
  input  wire logic               interface_select,
  input  wire logic               byte_order_swap,
  input  wire logic               channel_pick,
  input  wire logic               chip_select_n,
  input  wire logic               read_strobe_n,
  input  wire dsa_pkg::dsa_pair_t pair_one,
  input  wire dsa_pkg::dsa_pair_t pair_two,
  output logic                    busy,
  output logic                    low_power,
  output logic [15:0]             data_out,
  output logic                    data_oe_n,
  output logic                    serial_out_line,
  output logic                    serial_oe_n
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  dsa_pkg::dsa_pins_t pins;
  logic               start_prev;
  logic               start_fall;

  // Every control pin is asynchronous to clk, so all nine pass two flops
  dsa_sync #(
    .W   (dsa_pkg::PIN_N),
    .RST (dsa_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({conversion_start_n, power_down, impulse_mode,
               input_pair_select, interface_select, byte_order_swap,
               channel_pick, chip_select_n, read_strobe_n}),
    .dout    (pins)
  );

  // Start edge detector on the synchronised level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_prev <= 1'b1;
    end else begin
      start_prev <= pins.start_n;
    end
  end

  assign start_fall = start_prev & ~pins.start_n;

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  dsa_pkg::dsa_state_t        state;
  logic [dsa_pkg::CNT_W-1:0]  conv_cnt;
  logic [dsa_pkg::CNT_W-1:0]  acq_cnt;
  logic                       auto_armed;
  logic                       start_ok;
  logic                       conv_end;
  dsa_pkg::dsa_pair_t         held;

  // Self-restart needs a finished conversion and the start held low
  assign start_ok = ~pins.pd & (start_fall |
                    (pins.impulse & auto_armed & ~pins.start_n &
                     (acq_cnt == dsa_pkg::ACQ_DONE)));
  assign conv_end = (conv_cnt == dsa_pkg::CONV_LAST);

  // State, per-channel counter and busy; reset aborts the conversion
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= dsa_pkg::DSA_ACQ;
      conv_cnt <= dsa_pkg::CNT_ZERO;
      busy <= 1'b0;
    end else begin
      case (state)
        dsa_pkg::DSA_ACQ: begin
          conv_cnt <= dsa_pkg::CNT_ZERO;
          if (start_ok) begin
            state <= dsa_pkg::DSA_CONV_A;
            busy <= 1'b1;
          end
        end
        dsa_pkg::DSA_CONV_A: begin
          // Start and power-down are not looked at while converting
          if (conv_end) begin
            state <= dsa_pkg::DSA_CONV_B;
            conv_cnt <= dsa_pkg::CNT_ZERO;
          end else begin
            conv_cnt <= conv_cnt + dsa_pkg::CNT_ONE;
          end
        end
        dsa_pkg::DSA_CONV_B: begin
          if (conv_end) begin
            state <= dsa_pkg::DSA_ACQ;
            conv_cnt <= dsa_pkg::CNT_ZERO;
            busy <= 1'b0;
          end else begin
            conv_cnt <= conv_cnt + dsa_pkg::CNT_ONE;
          end
        end
        default: begin
          state <= dsa_pkg::DSA_ACQ;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Device-timed acquisition for the self-running mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acq_cnt <= dsa_pkg::CNT_ZERO;
      auto_armed <= 1'b0;
    end else begin
      if (state != dsa_pkg::DSA_ACQ) begin
        acq_cnt <= dsa_pkg::CNT_ZERO;
      end else if (acq_cnt != dsa_pkg::ACQ_DONE) begin
        acq_cnt <= acq_cnt + dsa_pkg::CNT_ONE;
      end
      // Armed only by a finished conversion: the first run needs a pulse
      if (state == dsa_pkg::DSA_CONV_B && conv_end) begin
        auto_armed <= pins.impulse;
      end else if (pins.start_n | ~pins.impulse) begin
        auto_armed <= 1'b0;
      end
    end
  end

  // Sample the chosen pair at the accepted start; codes pass unchanged
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      held <= '0;
    end else if (state == dsa_pkg::DSA_ACQ && start_ok) begin
      held <= pins.pair_sel ? pair_two : pair_one;
    end
  end

  // ****************************************************************
  // Results
  // ****************************************************************
  dsa_pkg::dsa_pair_t              res;
  logic [dsa_pkg::FRAME_W-1:0]     ser_word;
  logic                            ser_tgl;
  logic                            pick_prev;

  // Channel A is visible in parallel as soon as it is done
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res <= '0;
    end else if (conv_end && state == dsa_pkg::DSA_CONV_A) begin
      res.ch_a <= held.ch_a;
    end else if (conv_end && state == dsa_pkg::DSA_CONV_B) begin
      res.ch_b <= held.ch_b;
    end
  end

  // Serial word moves only after channel B, or when the order flips
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_word <= '0;
      ser_tgl <= 1'b0;
      pick_prev <= 1'b0;
    end else begin
      pick_prev <= pins.pick;
      if (conv_end && state == dsa_pkg::DSA_CONV_B) begin
        ser_word <= pins.pick ? {res.ch_a, held.ch_b}
                              : {held.ch_b, res.ch_a};
        ser_tgl <= ~ser_tgl;
      end else if (pins.pick != pick_prev) begin
        ser_word <= pins.pick ? {res.ch_a, res.ch_b}
                              : {res.ch_b, res.ch_a};
        ser_tgl <= ~ser_tgl;
      end
    end
  end

  // Word crosses by a toggle; the word itself is static by then
  // Limitation: two updates with no serial clock between them cancel
  dsa_ser_tx u_ser_tx (
    .serial_clk      (serial_clk),
    .sys_rst         (sys_rst),
    .word            (ser_word),
    .word_tgl        (ser_tgl),
    .serial_out_line (serial_out_line)
  );

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [dsa_pkg::RES_W-1:0] par_sel;

  assign par_sel = pins.pick ? res.ch_a : res.ch_b;

  // Parallel bus, with optional byte exchange for 8-bit hosts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= dsa_pkg::RES_RST;
    end else if (pins.swap) begin
      data_out <= {par_sel[dsa_pkg::BYTE_W-1:0],
                   par_sel[dsa_pkg::RES_W-1:dsa_pkg::BYTE_W]};
    end else begin
      data_out <= par_sel;
    end
  end

  // Enables: both strobes low and the matching mode; reset floats all
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_oe_n <= 1'b1;
      serial_oe_n <= 1'b1;
    end else begin
      data_oe_n <= pins.cs_n | pins.rd_n | pins.ser;
      serial_oe_n <= pins.cs_n | pins.rd_n | ~pins.ser;
    end
  end

  // Analog power scaled back between conversions in impulse mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_power <= 1'b0;
    end else begin
      low_power <= pins.pd |
                   (pins.impulse & (state == dsa_pkg::DSA_ACQ));
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  localparam int A_BUSY = 2 * dsa_pkg::CONV_CYC_I;
  localparam int A_BUSY_M1 = A_BUSY - 1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_busy_len;
    $rose(busy) |-> ##A_BUSY_M1 busy ##1 !busy;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("Busy width differs from two channel times");

  property p_no_abort;
    (state != dsa_pkg::DSA_ACQ && !conv_end) |=> busy && !$fell(busy);
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("Conversion ended before its time");

  property p_start_any_bus;
    (state == dsa_pkg::DSA_ACQ && start_fall && !pins.pd) |=> $rose(busy);
  endproperty
  a_start_any_bus: assert property (p_start_any_bus)
    else $error("Start edge was not accepted");

  property p_auto_run;
    (state == dsa_pkg::DSA_ACQ && pins.impulse && auto_armed &&
     !pins.start_n && !pins.pd && acq_cnt == dsa_pkg::ACQ_DONE)
      |=> $rose(busy);
  endproperty
  a_auto_run: assert property (p_auto_run)
    else $error("Self-running conversion did not restart");

  property p_normal_edge;
    (state == dsa_pkg::DSA_ACQ && !pins.impulse && !start_fall) |=> !busy;
  endproperty
  a_normal_edge: assert property (p_normal_edge)
    else $error("Normal mode started without a start edge");

  property p_float;
    (pins.cs_n || pins.rd_n) |=> data_oe_n && serial_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("Output driven without both strobes low");

  property p_continuous;
    (!pins.cs_n && !pins.rd_n && !pins.ser) [*2] |-> !data_oe_n;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("Parallel bus not driven with strobes low");

  property p_swap;
    (pins.swap && pins.pick) |=>
      data_out == {$past(res.ch_a[7:0]), $past(res.ch_a[15:8])};
  endproperty
  a_swap: assert property (p_swap)
    else $error("Swapped channel A bytes wrong");

  property p_a_first;
    (state == dsa_pkg::DSA_CONV_A && conv_end) |=>
      state == dsa_pkg::DSA_CONV_B && res.ch_a == $past(held.ch_a);
  endproperty
  a_a_first: assert property (p_a_first)
    else $error("Channel A not ready before channel B converts");

  property p_b_done;
    (state == dsa_pkg::DSA_CONV_B && conv_end) |=>
      res.ch_b == $past(held.ch_b) && res.ch_a == $past(res.ch_a);
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("Channel B result not kept after conversion");

  property p_ser_order;
    (state == dsa_pkg::DSA_CONV_B && conv_end && pins.pick) |=>
      ser_word == {$past(res.ch_a), $past(held.ch_b)};
  endproperty
  a_ser_order: assert property (p_ser_order)
    else $error("Serial word does not lead with channel A");

  property p_ser_mode;
    pins.ser |=> data_oe_n;
  endproperty
  a_ser_mode: assert property (p_ser_mode)
    else $error("Parallel bus driven in serial mode");

  property p_low_power;
    (pins.impulse && state == dsa_pkg::DSA_ACQ) |=> low_power;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("Impulse mode did not lower power between conversions");

  c_auto_run: cover property (auto_armed && $rose(busy));
  c_swap_read: cover property (!data_oe_n && pins.swap);
  c_par_read: cover property (!data_oe_n ##1 $fell(busy));
  c_ser_read: cover property (!serial_oe_n && $fell(busy));
  c_restart: cover property ($fell(busy) ##[1:40] $rose(busy));

endmodule : dsa_adc_if

// ### sim/dsa_host.sv
`timescale 1ns/1ps

// ****************************************************************
// Host model: start pin and serial clock of the far side
// ****************************************************************
module dsa_host (
  input  wire logic clk,
  input  wire logic serial_out_line,
  output logic      conversion_start_n,
  output logic      serial_clk
);
  // Serial clock stands low between frames, start idles high
  initial begin
    conversion_start_n = 1'b1;
    serial_clk = 1'b0;
  end

  // Three-clock start pulse, also the one-time kick after power-up
  task automatic pulse_start();
    @(posedge clk);
    conversion_start_n <= 1'b0;
    repeat (3) @(posedge clk);
    conversion_start_n <= 1'b1;
  endtask : pulse_start

  // Start held at a level; low keeps a self-running sequence alive
  task automatic hold_start(input logic lvl);
    @(posedge clk);
    conversion_start_n <= lvl;
  endtask : hold_start

  // Burst of 48 ns serial clocks; a bit is taken half a period after
  // each rise, so the shifter has settled and the next rise is far
  task automatic sclk_burst(input int n, output logic [31:0] word);
    word = 32'h0000_0000;
    #7;
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b1;
      #24;
      if (i >= 2 && i < 34) word[33-i] = serial_out_line;
      serial_clk = 1'b0;
      #24;
    end
  endtask : sclk_burst
endmodule : dsa_host

// ### sim/test_dsa_adc_if.sv
`timescale 1ns/1ps

// ****************************************************************
// Testbench for the converter host interface
// ****************************************************************
module test_dsa_adc_if;
  logic               clk;
  logic               sys_rst;
  logic               power_down;
  logic               impulse_mode;
  logic               input_pair_select;
  logic               interface_select;
  logic               byte_order_swap;
  logic               channel_pick;
  logic               chip_select_n;
  logic               read_strobe_n;
  dsa_pkg::dsa_pair_t pair_one;
  dsa_pkg::dsa_pair_t pair_two;
  logic               conversion_start_n;
  logic               serial_clk;
  logic               busy;
  logic               low_power;
  logic [15:0]        data_out;
  logic               data_oe_n;
  logic               serial_out_line;
  logic               serial_oe_n;
  int                 num_errors = 0;
  int                 num_checks = 0;

  // Front-end codes stay still for the whole run, so always settled
  initial begin
    clk = 1'b0;
    pair_one = 32'hA5C3_3C5A;
    pair_two = 32'hFFFF_0000;
  end

  // 100 MHz system clock
  always #5 clk = ~clk;

  dsa_adc_if u_dsa_adc_if (
    .clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .conversion_start_n(conversion_start_n), .power_down(power_down),
    .impulse_mode(impulse_mode), .input_pair_select(input_pair_select),
    .interface_select(interface_select),
    .byte_order_swap(byte_order_swap), .channel_pick(channel_pick),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .pair_one(pair_one), .pair_two(pair_two), .busy(busy),
    .low_power(low_power), .data_out(data_out), .data_oe_n(data_oe_n),
    .serial_out_line(serial_out_line), .serial_oe_n(serial_oe_n)
  );

  dsa_host u_dsa_host (
    .clk(clk), .serial_out_line(serial_out_line),
    .conversion_start_n(conversion_start_n), .serial_clk(serial_clk)
  );

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (busy !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("busy", busy, lvl);
  endtask : wait_busy

  // Parallel read; four edges cover the three-edge output latency
  task automatic rd_par(input logic pk, input logic sw,
                        input logic [15:0] exp);
    @(posedge clk);
    channel_pick <= pk;
    byte_order_swap <= sw;
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("data_oe_n", data_oe_n, 1'b0);
    check("data_out", data_out, exp);
  endtask : rd_par

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Channel A is on the bus while B still converts
  task automatic t_inflight();
    @(posedge clk);
    input_pair_select <= 1'b1;
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    u_dsa_host.pulse_start();
    wait_busy(1'b1, 10);
    repeat (45) @(negedge clk);
    check("busy_mid", busy, 1'b1);
    check("a_early", data_out, 16'hFFFF);
    wait_busy(1'b0, 60);
    rd_par(1'b0, 1'b0, 16'h0000);
    @(posedge clk);
    input_pair_select <= 1'b0;
    $display("t_inflight done");
  endtask : t_inflight

  // Fixed conversion length despite retrigger and power-down
  task automatic t_parallel();
    int n;
    n = 0;
    @(posedge clk);
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    u_dsa_host.pulse_start();
    wait_busy(1'b1, 10);
    fork
      while (busy === 1'b1) begin
        n++;
        @(negedge clk);
      end
      begin
        repeat (5) @(posedge clk);
        power_down <= 1'b1;
        u_dsa_host.pulse_start();
      end
    join
    check("busy_len", n, 80);
    u_dsa_host.pulse_start();
    repeat (10) @(negedge clk);
    check("pd_block", busy, 1'b0);
    @(posedge clk);
    power_down <= 1'b0;
    rd_par(1'b1, 1'b0, 16'hA5C3);
    rd_par(1'b1, 1'b1, 16'hC3A5);
    rd_par(1'b0, 1'b0, 16'h3C5A);
    rd_par(1'b0, 1'b1, 16'h5A3C);
    @(posedge clk);
    read_strobe_n <= 1'b1;
    repeat (5) @(negedge clk);
    check("rd_high", data_oe_n, 1'b1);
    @(posedge clk);
    read_strobe_n <= 1'b0;
    chip_select_n <= 1'b1;
    repeat (5) @(negedge clk);
    check("cs_high", data_oe_n, 1'b1);
    $display("t_parallel done");
  endtask : t_parallel

  // Serial frames in both channel orders
  task automatic t_serial();
    logic [31:0] w;
    @(posedge clk);
    interface_select <= 1'b1;
    channel_pick <= 1'b1;
    chip_select_n <= 1'b0;
    repeat (10) @(negedge clk);
    check("ser_oe", serial_oe_n, 1'b0);
    check("par_oe", data_oe_n, 1'b1);
    u_dsa_host.sclk_burst(34, w);
    check("frame_a", w, 32'hA5C3_3C5A);
    @(posedge clk);
    channel_pick <= 1'b0;
    repeat (10) @(posedge clk);
    u_dsa_host.sclk_burst(34, w);
    check("frame_b", w, 32'h3C5A_A5C3);
    @(posedge clk);
    interface_select <= 1'b0;
    $display("t_serial done");
  endtask : t_serial

  // Self-running conversions only in impulse mode
  task automatic t_impulse();
    logic rose;
    rose = 1'b0;
    @(posedge clk);
    impulse_mode <= 1'b1;
    u_dsa_host.hold_start(1'b0);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 100);
    repeat (3) @(negedge clk);
    check("low_power", low_power, 1'b1);
    check("oe_acq", data_oe_n, 1'b0);
    wait_busy(1'b1, 40);
    u_dsa_host.hold_start(1'b1);
    wait_busy(1'b0, 100);
    @(posedge clk);
    impulse_mode <= 1'b0;
    u_dsa_host.hold_start(1'b0);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 100);
    repeat (60) begin
      @(negedge clk);
      if (busy !== 1'b0) rose = 1'b1;
    end
    check("no_rerun", rose, 1'b0);
    u_dsa_host.hold_start(1'b1);
    $display("t_impulse done");
  endtask : t_impulse

  // Reset in mid-conversion aborts and floats the bus
  task automatic t_reset();
    logic [31:0] w;
    // Start pin rests high two cycles so the next fall is a clean edge
    repeat (2) @(posedge clk);
    u_dsa_host.pulse_start();
    wait_busy(1'b1, 10);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b1;
    fork
      u_dsa_host.sclk_burst(1, w);
      repeat (3) @(posedge clk);
    join
    @(negedge clk);
    check("rst_busy", busy, 1'b0);
    check("rst_oe", data_oe_n, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(negedge clk);
    check("aborted", busy, 1'b0);
    $display("t_reset done");
  endtask : t_reset

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    logic [31:0] w;
    sys_rst = 1'b1;
    power_down = 1'b0;
    impulse_mode = 1'b0;
    input_pair_select = 1'b0;
    interface_select = 1'b0;
    byte_order_swap = 1'b0;
    channel_pick = 1'b1;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    // One serial edge falls inside reset; reset lasts three clocks
    fork
      u_dsa_host.sclk_burst(1, w);
    join_none
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_inflight();
    t_parallel();
    t_serial();
    t_impulse();
    t_reset();
    tally_and_finish();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    #300000;
    num_errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule : test_dsa_adc_if
